// *** logic/rsh_pkg.sv ***
package rsh_pkg;
  localparam int NUM_IN = 4;
  localparam int SEL_W = 2;
  localparam int PRIO_W = 2;
  localparam int ADR_W = 8;
  localparam int DAT_W = 32;
  localparam int HCNT_W = 8;
  localparam int PRE_SEL_W = 5;
  localparam int PRE_W = 32;
  localparam int WIN_W = 3;
  localparam int WLIM_W = 9;

  localparam logic [ADR_W-1:0] ADDR_CTRL = 8'h00;
  localparam logic [ADR_W-1:0] ADDR_PRIO = 8'h04;
  localparam logic [ADR_W-1:0] ADDR_HOLDOFF = 8'h08;
  localparam logic [ADR_W-1:0] ADDR_LOCKWIN = 8'h0c;
  localparam logic [ADR_W-1:0] ADDR_STATUS = 8'h10;
  localparam logic [ADR_W-1:0] ADDR_STICKY = 8'h14;

  // control word fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_SEL_LSB = 2;
  localparam int CTRL_REVERTIVE_ENABLE_BIT = 4;
  localparam int CTRL_VBYP_BIT = 5;
  localparam int CTRL_FBYP_BIT = 6;
  localparam int CTRL_LOCKF_BIT = 7;
  localparam int CTRL_W = 8;
  // hold-off word fields
  localparam int HO_START_LSB = 0;
  localparam int HO_PRE_LSB = 8;
  localparam int HO_REVAL_LSB = 16;
  localparam int HO_W = 24;
  // lock window word fields
  localparam int LW_START_LSB = 0;
  localparam int LW_END_LSB = 4;
  localparam int LW_W = 7;
  // status word fields
  localparam int ST_VALID_LSB = 0;
  localparam int ST_SEL_LSB = 4;
  localparam int ST_REFV_BIT = 6;
  localparam int ST_HOLD_BIT = 7;
  localparam int ST_VUNL_BIT = 8;
  localparam int ST_FUNL_BIT = 9;
  localparam int ST_CNT_LSB = 16;
  // sticky word fields
  localparam int SK_INLOSS_LSB = 0;
  localparam int SK_REFLOSS_BIT = 4;
  localparam int SK_VUNL_BIT = 5;
  localparam int SK_FUNL_BIT = 6;

  localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;
  localparam logic [NUM_IN*PRIO_W-1:0] PRIO_RST = 8'he4;
  localparam logic [HO_W-1:0] HOLDOFF_RST = 24'h041110;
  localparam logic [LW_W-1:0] LOCKWIN_RST = 7'h22;

  localparam logic [WIN_W-1:0] WIN_HALF = 3'h0;
  localparam logic [WIN_W-1:0] WIN_ONE_HALF = 3'h1;
  localparam logic [WLIM_W-1:0] WLIM_HALF = 9'h001;
  localparam logic [WLIM_W-1:0] WLIM_ONE_HALF = 9'h003;

  typedef enum logic [1:0] {
    MODE_MANUAL = 2'h0,
    MODE_AUTO = 2'h1,
    MODE_SHORT_HOLD = 2'h2,
    MODE_AUTO_HOLD = 2'h3
  } rsh_mode_t;

  typedef enum logic [1:0] {
    RS_TRACK,
    RS_HOLD_SHORT,
    RS_HOLD_COUNT
  } rsh_state_t;
endpackage

// *** logic/rsh_ref_select.sv ***
// What this block does
// - a hold-off down-counter delays the switch after loss, auto-with-holdover only
// - counter transition to zero is expiry and triggers a fresh selection
// - counter ticks on vcxo output divided by prescaler, starts from 8-bit value
// - after expiry the counter reloads its start value
// - an input raises no new loss event until its sticky is cleared
// - counter runs only in auto-with-holdover while the countdown holdover state lasts
// - revertive enabled: revalidated input reselected only if it outranks current
// - revertive disabled (default): revalidation never changes the selection
// - short holdover: loss of designated ref enters holdover, selection unchanged
// - short holdover: designated ref revalidated ends holdover, ref valid again
// - writing 1 to the reference loss sticky bit clears it
// - auto-with-holdover: active loss enters holdover and starts countdown
// - all inputs stay monitored during countdown, loss shown live and sticky
// - revalidation during countdown changes no selection, revertive ignored
// - at zero, a revalidated active ref stays selected and holdover ends
// - at zero, else highest-priority valid input is selected, holdover ends
// - at zero with nothing valid, holdover stays and ref sticky not clearable
// - revertive switching resumes once holdover sequence ends
// - vcxo loop locked when feedback edge lies inside window, else unlock flags
// - window start in input periods, end in feedback periods, bypass scaled
// - window codes 000 and 001 mean half and one and a half periods
// - synth loop unlock shown live and sticky, optionally on lock pin
// - mode encoding: manual, automatic, short holdover, auto with holdover
// - per-input priority 0 lowest to 3 highest, changes may reselect
// - input valid again after revalidate_count consecutive edges
`timescale 1ns/1ps
module rsh_ref_select #(
  parameter int NUM_IN = rsh_pkg::NUM_IN
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [rsh_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [rsh_pkg::DAT_W-1:0] wb_dat_i,
  output logic [rsh_pkg::DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [NUM_IN-1:0] in_edge_i,
  input wire logic [NUM_IN-1:0] in_los_i,
  input wire logic vcxo_tick_i,
  input wire logic ref_half_tick_i,
  input wire logic vcxo_half_tick_i,
  input wire logic vco_mv1_half_tick_i,
  input wire logic pd_ref_i,
  input wire logic pd_fb_i,
  input wire logic synth_unlock_i,
  output logic [rsh_pkg::SEL_W-1:0] active_sel_o,
  output logic holdover_o,
  output logic ref_valid_o,
  output logic lock_o
);
  logic [rsh_pkg::CTRL_W-1:0] ctrl_r;
  logic [NUM_IN*rsh_pkg::PRIO_W-1:0] prio_r;
  logic [rsh_pkg::HO_W-1:0] holdoff_r;
  logic [rsh_pkg::LW_W-1:0] lockwin_r;
  logic [rsh_pkg::DAT_W-1:0] rd_nxt;
  logic bus_req, bus_wr, wr_sticky;
  logic [rsh_pkg::DAT_W-1:0] wmask;
  rsh_pkg::rsh_mode_t mode;
  logic [rsh_pkg::SEL_W-1:0] man_sel;
  logic revertive_enable, synth_byp, lockf_en;
  logic [rsh_pkg::HCNT_W-1:0] start_val;
  logic [rsh_pkg::PRE_SEL_W-1:0] pre_sel;
  logic [rsh_pkg::HCNT_W-1:0] reval_cnt;
  logic [NUM_IN-1:0] valid_r, sticky_r, los_d_r, loss_ev;
  rsh_pkg::rsh_state_t state_r;
  logic [rsh_pkg::SEL_W-1:0] sel_r;
  logic ref_valid_r, ref_loss_r;
  logic [rsh_pkg::HCNT_W-1:0] hold_cnt_r;
  logic [rsh_pkg::PRE_W-1:0] pre_cnt_r, pre_last;
  logic hold_run, hold_tick, hold_expire, hold_start, act_ev;
  logic best_any, outranks;
  logic [rsh_pkg::SEL_W-1:0] best_idx;
  logic [rsh_pkg::PRIO_W-1:0] best_prio;
  logic vunl_live_r, vunl_sticky_r, funl_sticky_r, funl_live_r;
  logic [rsh_pkg::WLIM_W-1:0] fb_age_r, late_cnt_r, tb_lim, te_lim;
  logic fb_fresh_r, late_r, fb_half_tick, lock_ev, unlock_ev;

  assign mode = rsh_pkg::rsh_mode_t'(ctrl_r[rsh_pkg::CTRL_MODE_LSB +: 2]);
  assign man_sel = ctrl_r[rsh_pkg::CTRL_SEL_LSB +: rsh_pkg::SEL_W];
  assign revertive_enable = ctrl_r[rsh_pkg::CTRL_REVERTIVE_ENABLE_BIT];
  assign synth_byp = ctrl_r[rsh_pkg::CTRL_FBYP_BIT];
  assign lockf_en = ctrl_r[rsh_pkg::CTRL_LOCKF_BIT];
  assign start_val = holdoff_r[rsh_pkg::HO_START_LSB +: rsh_pkg::HCNT_W];
  assign pre_sel = holdoff_r[rsh_pkg::HO_PRE_LSB +: rsh_pkg::PRE_SEL_W];
  assign reval_cnt = holdoff_r[rsh_pkg::HO_REVAL_LSB +: rsh_pkg::HCNT_W];

  // wishbone classic slave: ack one cycle after the request, write lands on the ack edge
  assign bus_req = wb_cyc_i & wb_stb_i;
  assign bus_wr = bus_req & wb_we_i & wb_ack_o;
  assign wr_sticky = bus_wr & (wb_adr_i == rsh_pkg::ADDR_STICKY);
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wmask[b*8 +: 8] = {8{wb_sel_i[b]}};
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= bus_req & ~wb_ack_o;
      wb_dat_o <= rd_nxt;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_r <= rsh_pkg::CTRL_RST;
      prio_r <= rsh_pkg::PRIO_RST;
      holdoff_r <= rsh_pkg::HOLDOFF_RST;
      lockwin_r <= rsh_pkg::LOCKWIN_RST;
    end else if (bus_wr) begin
      case (wb_adr_i)
        rsh_pkg::ADDR_CTRL:
          ctrl_r <= (ctrl_r & ~wmask[rsh_pkg::CTRL_W-1:0])
                    | (wb_dat_i[rsh_pkg::CTRL_W-1:0] & wmask[rsh_pkg::CTRL_W-1:0]);
        rsh_pkg::ADDR_PRIO:
          prio_r <= (prio_r & ~wmask[NUM_IN*rsh_pkg::PRIO_W-1:0])
                    | (wb_dat_i[NUM_IN*rsh_pkg::PRIO_W-1:0] & wmask[NUM_IN*rsh_pkg::PRIO_W-1:0]);
        rsh_pkg::ADDR_HOLDOFF:
          holdoff_r <= (holdoff_r & ~wmask[rsh_pkg::HO_W-1:0])
                       | (wb_dat_i[rsh_pkg::HO_W-1:0] & wmask[rsh_pkg::HO_W-1:0]);
        rsh_pkg::ADDR_LOCKWIN:
          lockwin_r <= (lockwin_r & ~wmask[rsh_pkg::LW_W-1:0])
                       | (wb_dat_i[rsh_pkg::LW_W-1:0] & wmask[rsh_pkg::LW_W-1:0]);
        default: begin
        end
      endcase
    end
  end

  always_comb begin
    rd_nxt = '0;
    case (wb_adr_i)
      rsh_pkg::ADDR_CTRL: rd_nxt[rsh_pkg::CTRL_W-1:0] = ctrl_r;
      rsh_pkg::ADDR_PRIO: rd_nxt[NUM_IN*rsh_pkg::PRIO_W-1:0] = prio_r;
      rsh_pkg::ADDR_HOLDOFF: rd_nxt[rsh_pkg::HO_W-1:0] = holdoff_r;
      rsh_pkg::ADDR_LOCKWIN: rd_nxt[rsh_pkg::LW_W-1:0] = lockwin_r;
      rsh_pkg::ADDR_STATUS: begin
        rd_nxt[rsh_pkg::ST_VALID_LSB +: NUM_IN] = valid_r;
        rd_nxt[rsh_pkg::ST_SEL_LSB +: rsh_pkg::SEL_W] = sel_r;
        rd_nxt[rsh_pkg::ST_REFV_BIT] = ref_valid_r;
        rd_nxt[rsh_pkg::ST_HOLD_BIT] = (state_r != rsh_pkg::RS_TRACK);
        rd_nxt[rsh_pkg::ST_VUNL_BIT] = vunl_live_r;
        rd_nxt[rsh_pkg::ST_FUNL_BIT] = funl_live_r;
        rd_nxt[rsh_pkg::ST_CNT_LSB +: rsh_pkg::HCNT_W] = hold_cnt_r;
      end
      rsh_pkg::ADDR_STICKY: begin
        rd_nxt[rsh_pkg::SK_INLOSS_LSB +: NUM_IN] = sticky_r;
        rd_nxt[rsh_pkg::SK_REFLOSS_BIT] = ref_loss_r;
        rd_nxt[rsh_pkg::SK_VUNL_BIT] = vunl_sticky_r;
        rd_nxt[rsh_pkg::SK_FUNL_BIT] = funl_sticky_r;
      end
      default: rd_nxt = '0;
    endcase
  end

  // per-input monitor: live validity, revalidation count and loss sticky
  genvar gi;
  generate
    for (gi = 0; gi < NUM_IN; gi++) begin : g_in
      logic [rsh_pkg::HCNT_W-1:0] vcnt_r;
      // an unacknowledged loss blocks further events from this input
      assign loss_ev[gi] = in_los_i[gi] & ~los_d_r[gi] & ~sticky_r[gi];
      always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          valid_r[gi] <= 1'b0;
          vcnt_r <= '0;
          los_d_r[gi] <= 1'b0;
        end else begin
          los_d_r[gi] <= in_los_i[gi];
          if (in_los_i[gi]) begin
            valid_r[gi] <= 1'b0;
            vcnt_r <= '0;
          end else if (!valid_r[gi] && in_edge_i[gi]) begin
            if (vcnt_r + 1'b1 >= reval_cnt) begin
              valid_r[gi] <= 1'b1;
              vcnt_r <= '0;
            end else begin
              vcnt_r <= vcnt_r + 1'b1;
            end
          end
        end
      end
      always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          sticky_r[gi] <= 1'b0;
        end else if (loss_ev[gi]) begin
          sticky_r[gi] <= 1'b1;
        end else if (wr_sticky && wb_sel_i[0] && wb_dat_i[rsh_pkg::SK_INLOSS_LSB + gi]
                     && valid_r[gi]) begin
          sticky_r[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // highest priority valid input; ties go to the lowest index
  always_comb begin
    best_any = 1'b0;
    best_idx = '0;
    best_prio = '0;
    for (int i = 0; i < NUM_IN; i++) begin
      if (valid_r[i] && (!best_any || prio_r[i*rsh_pkg::PRIO_W +: rsh_pkg::PRIO_W] > best_prio)) begin
        best_any = 1'b1;
        best_idx = rsh_pkg::SEL_W'(i);
        best_prio = prio_r[i*rsh_pkg::PRIO_W +: rsh_pkg::PRIO_W];
      end
    end
  end
  assign outranks = best_any && (best_prio > prio_r[sel_r*rsh_pkg::PRIO_W +: rsh_pkg::PRIO_W]);
  assign act_ev = loss_ev[sel_r];
  assign hold_start = (state_r == rsh_pkg::RS_TRACK) && (mode == rsh_pkg::MODE_AUTO_HOLD)
                      && act_ev;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= rsh_pkg::RS_TRACK;
      sel_r <= '0;
      ref_valid_r <= 1'b0;
    end else begin
      case (state_r)
        rsh_pkg::RS_TRACK: begin
          case (mode)
            rsh_pkg::MODE_SHORT_HOLD: begin
              sel_r <= man_sel;
              if (act_ev) begin
                state_r <= rsh_pkg::RS_HOLD_SHORT;
                ref_valid_r <= 1'b0;
              end else begin
                ref_valid_r <= valid_r[man_sel];
              end
            end
            rsh_pkg::MODE_AUTO: begin
              if ((!valid_r[sel_r] || (revertive_enable && outranks)) && best_any) begin
                sel_r <= best_idx;
                ref_valid_r <= 1'b1;
              end else begin
                ref_valid_r <= valid_r[sel_r];
              end
            end
            rsh_pkg::MODE_AUTO_HOLD: begin
              if (act_ev) begin
                state_r <= rsh_pkg::RS_HOLD_COUNT;
                ref_valid_r <= 1'b0;
              end else if (revertive_enable && outranks) begin
                sel_r <= best_idx;
                ref_valid_r <= 1'b1;
              end else begin
                ref_valid_r <= valid_r[sel_r];
              end
            end
            default: begin
              sel_r <= man_sel;
              ref_valid_r <= valid_r[man_sel];
            end
          endcase
        end
        rsh_pkg::RS_HOLD_SHORT: begin
          if (mode != rsh_pkg::MODE_SHORT_HOLD) begin
            state_r <= rsh_pkg::RS_TRACK;
          end else if (valid_r[sel_r]) begin
            state_r <= rsh_pkg::RS_TRACK;
            ref_valid_r <= 1'b1;
          end
        end
        rsh_pkg::RS_HOLD_COUNT: begin
          // revertive and priority changes are ignored until expiry
          if (mode != rsh_pkg::MODE_AUTO_HOLD) begin
            state_r <= rsh_pkg::RS_TRACK;
          end else if (hold_expire) begin
            if (valid_r[sel_r]) begin
              state_r <= rsh_pkg::RS_TRACK;
              ref_valid_r <= 1'b1;
            end else if (best_any) begin
              sel_r <= best_idx;
              state_r <= rsh_pkg::RS_TRACK;
              ref_valid_r <= 1'b1;
            end
          end
        end
        default: state_r <= rsh_pkg::RS_TRACK;
      endcase
    end
  end

  // reference loss sticky reads 1 when clear; loss wins over a same-cycle write
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ref_loss_r <= 1'b1;
    end else if (act_ev) begin
      ref_loss_r <= 1'b0;
    end else if (wr_sticky && wb_sel_i[0] && wb_dat_i[rsh_pkg::SK_REFLOSS_BIT]
                 && ref_valid_r) begin
      ref_loss_r <= 1'b1;
    end
  end

  // hold-off prescaler and down-counter, gated off outside the countdown
  assign hold_run = (state_r == rsh_pkg::RS_HOLD_COUNT) && (mode == rsh_pkg::MODE_AUTO_HOLD);
  assign pre_last = (rsh_pkg::PRE_W'(1) << pre_sel) - rsh_pkg::PRE_W'(1);
  assign hold_tick = hold_run && vcxo_tick_i && (pre_cnt_r == pre_last);
  assign hold_expire = hold_tick && (hold_cnt_r <= rsh_pkg::HCNT_W'(1));

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pre_cnt_r <= '0;
    end else if (!hold_run) begin
      pre_cnt_r <= '0;
    end else if (vcxo_tick_i) begin
      pre_cnt_r <= (pre_cnt_r == pre_last) ? '0 : pre_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hold_cnt_r <= '0;
    end else if (hold_start) begin
      hold_cnt_r <= start_val;
    end else if (hold_expire) begin
      hold_cnt_r <= start_val;
    end else if (hold_tick) begin
      hold_cnt_r <= hold_cnt_r - 1'b1;
    end
  end

  // lock window limits in half periods; code 0 and 1 are half and 1.5 periods
  function automatic logic [rsh_pkg::WLIM_W-1:0] win_lim(input logic [rsh_pkg::WIN_W-1:0] c);
    if (c == rsh_pkg::WIN_HALF) begin
      win_lim = rsh_pkg::WLIM_HALF;
    end else if (c == rsh_pkg::WIN_ONE_HALF) begin
      win_lim = rsh_pkg::WLIM_ONE_HALF;
    end else begin
      win_lim = ((rsh_pkg::WLIM_W'(1) << c) - rsh_pkg::WLIM_W'(1)) << 1;
    end
  endfunction
  assign tb_lim = win_lim(lockwin_r[rsh_pkg::LW_START_LSB +: rsh_pkg::WIN_W]);
  assign te_lim = win_lim(lockwin_r[rsh_pkg::LW_END_LSB +: rsh_pkg::WIN_W]);
  // with the synth loop bypassed the late side counts vco periods scaled by its divider
  assign fb_half_tick = synth_byp ? vco_mv1_half_tick_i : vcxo_half_tick_i;
  assign lock_ev = (pd_ref_i && fb_fresh_r && fb_age_r <= tb_lim) || (late_r && pd_fb_i);
  assign unlock_ev = (pd_ref_i && late_r)
                     || (late_r && !pd_fb_i && fb_half_tick && late_cnt_r >= te_lim);

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fb_age_r <= '0;
      fb_fresh_r <= 1'b0;
      late_r <= 1'b0;
      late_cnt_r <= '0;
    end else begin
      if (pd_fb_i) begin
        fb_age_r <= '0;
      end else if (ref_half_tick_i && fb_age_r != '1) begin
        fb_age_r <= fb_age_r + 1'b1;
      end
      // a feedback edge consumed by the late window must not also count as early
      if (pd_ref_i) begin
        fb_fresh_r <= 1'b0;
      end else if (pd_fb_i && !late_r) begin
        fb_fresh_r <= 1'b1;
      end
      if (pd_ref_i && !(fb_fresh_r && fb_age_r <= tb_lim)) begin
        late_r <= 1'b1;
        late_cnt_r <= '0;
      end else if (lock_ev || unlock_ev) begin
        late_r <= 1'b0;
      end else if (late_r && fb_half_tick) begin
        late_cnt_r <= late_cnt_r + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      vunl_live_r <= 1'b1;
      vunl_sticky_r <= 1'b0;
      funl_live_r <= 1'b0;
      funl_sticky_r <= 1'b0;
    end else begin
      if (unlock_ev) begin
        vunl_live_r <= 1'b1;
      end else if (lock_ev) begin
        vunl_live_r <= 1'b0;
      end
      if (unlock_ev) begin
        vunl_sticky_r <= 1'b1;
      end else if (wr_sticky && wb_sel_i[0] && wb_dat_i[rsh_pkg::SK_VUNL_BIT]) begin
        vunl_sticky_r <= 1'b0;
      end
      funl_live_r <= synth_unlock_i;
      if (synth_unlock_i) begin
        funl_sticky_r <= 1'b1;
      end else if (wr_sticky && wb_sel_i[0] && wb_dat_i[rsh_pkg::SK_FUNL_BIT]) begin
        funl_sticky_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      active_sel_o <= '0;
      holdover_o <= 1'b0;
      ref_valid_o <= 1'b0;
      lock_o <= 1'b0;
    end else begin
      active_sel_o <= sel_r;
      holdover_o <= (state_r != rsh_pkg::RS_TRACK);
      ref_valid_o <= ref_valid_r;
      lock_o <= !vunl_live_r && !(lockf_en && funl_live_r);
    end
  end

  a_ack_single_pulse: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    wb_ack_o |=> !wb_ack_o) else $error("ack held more than one cycle");
  a_sticky_sets_loss: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    loss_ev[0] |=> sticky_r[0] && !valid_r[0]) else $error("loss event not latched");
  a_revalid_on_edge: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    $rose(valid_r[0]) |-> $past(in_edge_i[0]) && !$past(in_los_i[0]))
    else $error("input validated without an edge");
  a_holdoff_gated_off: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !hold_run |=> pre_cnt_r == '0) else $error("prescaler ran outside countdown");
  a_holdoff_start_load: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    hold_start |=> state_r == rsh_pkg::RS_HOLD_COUNT && !ref_valid_r && !ref_loss_r
    && hold_cnt_r == $past(start_val)) else $error("countdown did not start");
  a_expiry_reloads: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    hold_expire |=> hold_cnt_r == $past(start_val)) else $error("counter not reloaded");
  a_short_keeps_sel: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    state_r == rsh_pkg::RS_HOLD_SHORT |=> sel_r == $past(sel_r))
    else $error("selection moved in short holdover");
  a_countdown_frozen: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    hold_run && !hold_expire |=> sel_r == $past(sel_r) && !ref_valid_r)
    else $error("selection moved during countdown");
  a_expire_keeps_ref: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    hold_expire && valid_r[sel_r] |=> state_r == rsh_pkg::RS_TRACK && ref_valid_r
    && sel_r == $past(sel_r)) else $error("revalidated reference not kept");
  a_expire_none_valid: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    hold_expire && !best_any |=> state_r == rsh_pkg::RS_HOLD_COUNT && !ref_valid_r)
    else $error("holdover left with no valid input");
  a_nonrev_no_switch: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    state_r == rsh_pkg::RS_TRACK && !revertive_enable && valid_r[sel_r] && !act_ev
    && (mode == rsh_pkg::MODE_AUTO || mode == rsh_pkg::MODE_AUTO_HOLD)
    |=> sel_r == $past(sel_r)) else $error("switch without revertive");
endmodule

// *** sim/rsh_ref_model.sv ***
`timescale 1ns/1ps
module rsh_ref_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [3:0] lost_i,
  input wire logic lock_ok_i,
  output logic [3:0] edge_o,
  output logic [3:0] los_o,
  output logic tick_o,
  output logic pd_ref_o,
  output logic pd_fb_o
);
  logic [4:0] cnt_r;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= 5'h00;
    end else begin
      cnt_r <= cnt_r + 5'h01;
    end
  end
  // a lost input shows no edges at all, so revalidation counts only real ones
  assign edge_o = ~lost_i & {4{cnt_r[1:0] == 2'h0}};
  assign los_o = lost_i;
  assign tick_o = cnt_r[0];
  assign pd_ref_o = cnt_r == 5'h00;
  // far edge sits outside both window sides, near edge well inside
  assign pd_fb_o = cnt_r == (lock_ok_i ? 5'h01 : 5'h10);
endmodule

// *** sim/ref_select_holdover_lock_detect_tb.sv ***
`timescale 1ns/1ps
module ref_select_holdover_lock_detect_tb;
  logic clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, ack, lk, hold, refv, ok = 1;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hf, edg, los, lost = 4'h0;
  logic [31:0] dw = 32'h0, dr, r;
  logic [1:0] act;
  logic tk, pr, pf;
  int miscompares = 0, num_checks = 0;
  logic [31:0] expq[$];
  initial forever #12.5 clk = ~clk;
  rsh_ref_model pm (.clk_i(clk), .rst_n_i(rst_n), .lost_i(lost), .lock_ok_i(ok),
    .edge_o(edg), .los_o(los), .tick_o(tk), .pd_ref_o(pr), .pd_fb_o(pf));
  rsh_ref_select uut (.core_clk_i(clk), .rst_n_i(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr),
    .wb_ack_o(ack), .in_edge_i(edg), .in_los_i(los), .vcxo_tick_i(tk),
    .ref_half_tick_i(tk), .vcxo_half_tick_i(tk), .vco_mv1_half_tick_i(tk),
    .pd_ref_i(pr), .pd_fb_i(pf), .synth_unlock_i(1'b0), .active_sel_o(act),
    .holdover_o(hold), .ref_valid_o(refv), .lock_o(lk));
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  always @(posedge clk) if (ack === 1'b1 && !we) cmp(dr, expq.pop_front());
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    cyc <= 1; stb <= 1; we <= w; adr <= a; dw <= d;
    if (!w) expq.push_back(d);
    n = 0;
    do begin @(posedge clk); n++; end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin miscompares++; summarize(); end
    cyc <= 0; stb <= 0;
    @(posedge clk);
  endtask
  task automatic st(input int c, input logic [3:0] e);
    repeat (c) @(posedge clk);
    #1 cmp({28'h0, act, hold, refv}, {28'h0, e});
    // return on an edge so the next stimulus lands on the rising edge
    @(posedge clk);
  endtask
  task automatic wl(input logic v);
    int n;
    n = 0;
    do begin @(posedge clk); n++; end while (lk !== v && n < 400);
    cmp({31'h0, lk}, {31'h0, v});
    if (lk !== v) summarize();
  endtask
  initial begin
    void'($urandom(32'hd9b99bd5));
    repeat (12) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    wb(0, rsh_pkg::ADDR_CTRL, 32'(rsh_pkg::CTRL_RST));
    wb(0, rsh_pkg::ADDR_PRIO, 32'(rsh_pkg::PRIO_RST));
    wb(0, rsh_pkg::ADDR_HOLDOFF, 32'(rsh_pkg::HOLDOFF_RST));
    wb(0, rsh_pkg::ADDR_LOCKWIN, 32'(rsh_pkg::LOCKWIN_RST));
    wb(0, 8'h18, 32'h0);
    $display("test reset done");
    wb(1, rsh_pkg::ADDR_HOLDOFF, 32'h010004);
    wb(1, rsh_pkg::ADDR_CTRL, 32'h01);
    repeat (20) @(posedge clk);
    wb(1, rsh_pkg::ADDR_STICKY, 32'h7f);
    lost <= 4'h7;
    st(20, 4'hd);
    wb(0, rsh_pkg::ADDR_STICKY, 32'h07);
    lost <= 4'h0;
    repeat (20) @(posedge clk);
    wb(1, rsh_pkg::ADDR_STICKY, 32'h7f);
    wb(1, rsh_pkg::ADDR_CTRL, 32'h03);
    repeat (5) @(posedge clk);
    lost <= 4'h8;
    st(3, 4'he);
    st(30, 4'h9);
    $display("test auto holdover done");
    lost <= 4'h0;
    st(20, 4'h9);
    wb(1, rsh_pkg::ADDR_STICKY, 32'h7f);
    wb(1, rsh_pkg::ADDR_CTRL, 32'h06);
    repeat (10) @(posedge clk);
    lost <= 4'h2;
    st(3, 4'h6);
    lost <= 4'h0;
    st(20, 4'h5);
    $display("test short holdover done");
    wb(1, rsh_pkg::ADDR_LOCKWIN, 32'h22);
    ok <= 1;
    wl(1);
    ok <= 0;
    wl(0);
    $display("test lock done");
    wb(1, rsh_pkg::ADDR_CTRL, 32'h11);
    st(5, 4'hd);
    $display("test revertive done");
    r = $urandom;
    wb(1, rsh_pkg::ADDR_PRIO, r);
    wb(0, rsh_pkg::ADDR_PRIO, {24'h0, r[7:0]});
    $display("test priority done");
    summarize();
  end
endmodule
